// ### src/rsc_reference_switchover_control.sv
// reference switchover controller: picks the active input reference
// for the digital phase loop and flags holdover, free-run and build-out
// assumes validity flags and the reference-to-profile table come from
// logic on clk_i, and a classic wishbone master on the same clock
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] mode field picks auto, fallback, holdover, manual
// [R2] auto mode ignores the user reference field
// [R3] user code 000 first input, 111 eighth
// [R4] fallback: user if valid, else priority pick
// [R5] holdover mode: user if valid, else holdover
// [R6] manual: user reference regardless of validity
// [R7] software sets manual profile for user reference
// [R8] bit 6 forces holdover, bit 5 free-run
// [R9] free-run frequency comes from tuning word
// [R10] selection and promoted priority 0..7, lower wins
// [R11] promoted priority applies only to active reference
// [R12] switch on failure or better newly valid reference
// [R13] pick valid reference with lowest selection priority
// [R14] equal priority ties go to lowest index
// [R15] invalid references are never candidates
// [R16] differential inputs: lower index gets better priority
// [R17] phase master: selection priority below threshold
// [R18] threshold resets to zero, no masters
// [R19] build-out on switch only if not master
// [R20] null profile assignment counts as invalid
// [R21] table entry: bit 7 assigned, bits 6:4 profile
// [R22] selection decisions are registered on clock
// [R23] free-run wins over forced holdover
module rsc_reference_switchover_control
    import rsc_pkg::*;
#(
    parameter int NUM_REFS = 8,
    parameter int FTW_BYTES = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_REFS-1:0] ref_valid_i,
    input wire logic [8*NUM_REFS-1:0] ref_profile_i,
    output logic [2:0] active_ref_o,
    output logic ref_active_o,
    output logic holdover_o,
    output logic free_run_o,
    output logic [8*FTW_BYTES-1:0] ftw_o,
    output logic switch_o,
    output logic phase_buildout_o
);
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic [7:0] loop_mode_ff;
    logic [7:0] pbo_thresh_ff;
    logic [7:0] ftw_ff [FTW_BYTES];
    logic [7:0] prio_ff [8];
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [11:0] idx;
    logic req;
    logic wr_en;
    rsc_state_e state_ff;
    rsc_state_e nxt_state;
    logic [2:0] active_ff;
    logic [2:0] nxt_active;
    logic switch_ff;
    logic pbo_ff;

    assign idx = wb_adr_i[13:2];
    // a request still held after ack must not be taken a second time
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_en = req & wb_we_i & wb_sel_i[0];
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ----------------------------------------------------------------
    // address decode; the write path uses only the loop and threshold hits
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [11:0] a,
                                      input logic [11:0] lo,
                                      input logic [11:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic hit_loop;
    logic hit_thresh;
    logic hit_status;
    logic hit_ftw;
    logic hit_prio;

    assign hit_loop = (idx == RSC_IDX_LOOP_MODE);
    assign hit_thresh = (idx == RSC_IDX_PBO_THRESH);
    assign hit_status = (idx == RSC_IDX_STATUS);
    assign hit_ftw = in_range(idx, RSC_IDX_FTW0, RSC_IDX_FTW5);
    assign hit_prio = in_range(idx, RSC_IDX_PRIO0, RSC_IDX_PRIO7);

    // status byte, assembled once so the read path stays a plain mux
    logic [7:0] status_byte;
    assign status_byte[7] = (state_ff == RSC_ST_TRACK);
    assign status_byte[6] = (state_ff == RSC_ST_FREE);
    assign status_byte[5] = (state_ff == RSC_ST_HOLD);
    assign status_byte[4] = pbo_ff;
    assign status_byte[3] = 1'b0;
    assign status_byte[2:0] = active_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_mode_ff <= RSC_RST_LOOP_MODE;
            pbo_thresh_ff <= RSC_RST_PBO_THRESH; // R18
        end else if (wr_en) begin
            // unused high bits are dropped so read-back shows what is kept
            if (hit_loop) begin
                loop_mode_ff <= {1'b0, wb_dat_i[6:0]};
            end
            if (hit_thresh) begin
                pbo_thresh_ff <= {5'h00, wb_dat_i[2:0]};
            end
        end
    end

    // the tuning word is not double-buffered: a multi-byte update is seen
    // byte by byte, so change it only while the loop is not free-running
    genvar g;
    generate
        for (g = 0; g < FTW_BYTES; g++) begin : gen_ftw
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ftw_ff[g] <= RSC_RST_FTW_BYTE;
                end else if (wr_en && idx == RSC_IDX_FTW0 + 12'(g)) begin
                    ftw_ff[g] <= wb_dat_i[7:0];
                end
            end
            assign ftw_o[8*g +: 8] = ftw_ff[g]; // R9
        end
        for (g = 0; g < 8; g++) begin : gen_prio
            // bits 2:0 selection priority, bits 6:4 promoted priority
            // the spare bits of each priority byte read back as zero
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    prio_ff[g] <= RSC_RST_PRIO;
                end else if (wr_en && idx == RSC_IDX_PRIO0 + 12'(g)) begin
                    prio_ff[g] <= {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]}; // R10
                end
            end
        end
    endgenerate

    // status: bit 7 tracking, 6 free-run, 5 holdover, 4 build-out, 2:0 active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdat_ff <= 32'h0000_0000;
            if (hit_loop) begin
                rdat_ff[7:0] <= loop_mode_ff;
            end else if (hit_thresh) begin
                rdat_ff[7:0] <= pbo_thresh_ff;
            end else if (hit_ftw) begin
                rdat_ff[7:0] <= ftw_ff[3'(idx - RSC_IDX_FTW0)];
            end else if (hit_prio) begin
                rdat_ff[7:0] <= prio_ff[3'(idx - RSC_IDX_PRIO0)];
            end else if (hit_status) begin
                rdat_ff[7:0] <= status_byte;
            end
        end
    end

    // ----------------------------------------------------------------
    // candidate evaluation
    // ----------------------------------------------------------------
    function automatic logic [2:0] prof_of(input logic [8*NUM_REFS-1:0] tbl,
                                           input logic [2:0] r);
        prof_of = tbl[8*r + RSC_TBL_PROF_LSB +: 3]; // R21
    endfunction

    function automatic logic [2:0] sel_pri(input logic [7:0] p);
        sel_pri = p[RSC_PRIO_SEL_LSB +: 3];
    endfunction

    function automatic logic [2:0] prom_pri(input logic [7:0] p);
        prom_pri = p[RSC_PRIO_PROM_LSB +: 3];
    endfunction

    logic [7:0] cand;
    logic [2:0] pri_sel [8];
    logic [2:0] pri_prom [8];
    logic [2:0] best_idx;
    logic best_ok;
    logic [2:0] best_pri;

    generate
        for (g = 0; g < 8; g++) begin : gen_cand
            if (g < NUM_REFS) begin : gen_used
                // null table entry means the input is not a candidate
                assign cand[g] = ref_valid_i[g] &
                                 ref_profile_i[8*g + RSC_TBL_ASSIGNED_BIT]; // R15 R20
                assign pri_sel[g] = sel_pri(prio_ff[prof_of(ref_profile_i, 3'(g))]);
                assign pri_prom[g] = prom_pri(prio_ff[prof_of(ref_profile_i, 3'(g))]);
            end else begin : gen_unused
                assign cand[g] = 1'b0;
                assign pri_sel[g] = 3'h7;
                assign pri_prom[g] = 3'h7;
            end
        end
    endgenerate

    // strict compare while scanning upward keeps the lowest index on ties
    always_comb begin
        best_ok = 1'b0;
        best_idx = 3'h0;
        best_pri = 3'h7;
        for (int i = 0; i < 8; i++) begin
            if (cand[i] && (!best_ok || pri_sel[i] < best_pri)) begin // R13 R14
                best_ok = 1'b1;
                best_idx = 3'(i);
                best_pri = pri_sel[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // selection decision
    // ----------------------------------------------------------------
    rsc_mode_e mode;
    logic [2:0] user_ref;
    logic force_hold;
    logic force_free;
    logic tracking;
    logic auto_ref_ok;
    logic [2:0] auto_ref;

    assign mode = rsc_mode_e'(loop_mode_ff[RSC_LM_MODE_MSB:RSC_LM_MODE_LSB]); // R1
    assign user_ref = loop_mode_ff[RSC_LM_USER_MSB:0]; // R3
    assign force_hold = loop_mode_ff[RSC_LM_FORCE_HOLD_BIT];
    assign force_free = loop_mode_ff[RSC_LM_FORCE_FREE_BIT];
    assign tracking = (state_ff == RSC_ST_TRACK);

    // outside manual mode the user input is usable only when it is a candidate
    logic user_ok;
    assign user_ok = cand[user_ref];

    // candidates are re-scored every cycle; a chattering valid flag can bounce
    // the choice, so debouncing is left to the validation monitors
    // the active input is judged by its promoted priority, others by selection
    always_comb begin
        auto_ref_ok = best_ok;
        auto_ref = best_idx;
        if (tracking && cand[active_ff]) begin // R12
            auto_ref = active_ff;
            if (best_ok && best_idx != active_ff && best_pri < pri_prom[active_ff]) begin // R11
                auto_ref = best_idx;
            end
        end
    end

    always_comb begin
        nxt_state = RSC_ST_HOLD;
        nxt_active = active_ff;
        // free-run is checked first: with both force bits set the loop must idle
        if (force_free) begin // R23
            nxt_state = RSC_ST_FREE; // R8
        end else if (force_hold) begin
            nxt_state = RSC_ST_HOLD; // R8
        end else begin
            case (mode)
                RSC_MODE_AUTO: begin
                    // user field is not looked at here
                    if (auto_ref_ok) begin // R2
                        nxt_state = RSC_ST_TRACK;
                        nxt_active = auto_ref;
                    end
                end
                RSC_MODE_FALLBACK: begin
                    if (user_ok) begin // R4
                        nxt_state = RSC_ST_TRACK;
                        nxt_active = user_ref;
                    end else if (auto_ref_ok) begin
                        nxt_state = RSC_ST_TRACK;
                        nxt_active = auto_ref;
                    end
                end
                RSC_MODE_HOLDOVER: begin
                    if (user_ok) begin // R5
                        nxt_state = RSC_ST_TRACK;
                        nxt_active = user_ref;
                    end
                end
                RSC_MODE_MANUAL: begin
                    // relies on software keeping a manual profile here
                    nxt_state = RSC_ST_TRACK; // R6 R7
                    nxt_active = user_ref;
                end
                default: begin
                    nxt_state = RSC_ST_HOLD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic new_ref;
    logic enter_track;
    logic ref_moved;
    logic new_master;

    assign enter_track = (nxt_state == RSC_ST_TRACK) && !tracking;
    assign ref_moved = (nxt_state == RSC_ST_TRACK) && tracking && (nxt_active != active_ff);
    // re-entering the same input after holdover still counts as a change
    assign new_ref = enter_track | ref_moved;
    // a master is strictly better than the threshold, so threshold 0 has none
    assign new_master = (pri_sel[nxt_active] < pbo_thresh_ff[2:0]); // R17 R18

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= RSC_ST_HOLD;
            active_ff <= 3'h0;
        end else begin
            // index and state move on one edge so a status read is never torn
            state_ff <= nxt_state; // R22
            active_ff <= nxt_active;
        end
    end

    // the build-out status bit is sticky until the next reference change; phase_buildout_o only pulses with switch_o
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_ff <= 1'b0;
            pbo_ff <= 1'b0;
        end else begin
            switch_ff <= new_ref;
            if (new_ref) begin
                pbo_ff <= !new_master; // R19
            end
        end
    end

    // ----------------------------------------------------------------
    // output ports
    // ----------------------------------------------------------------
    assign active_ref_o = active_ff;
    assign ref_active_o = tracking;
    assign holdover_o = (state_ff == RSC_ST_HOLD);
    assign free_run_o = (state_ff == RSC_ST_FREE);
    assign switch_o = switch_ff;
    assign phase_buildout_o = switch_ff & pbo_ff;
    // R16 is a board guideline; the pick logic applies whatever is set
    // manual mode trusts software to keep the user input's profile pinned
endmodule

`default_nettype wire

// ### src/rsc_pkg.sv
// constants shared by the reference switchover controller
// assumes a single 200 MHz system clock domain
package rsc_pkg;
    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [11:0] RSC_IDX_FTW0 = 12'h300;
    localparam logic [11:0] RSC_IDX_FTW5 = 12'h305;
    localparam logic [11:0] RSC_IDX_PBO_THRESH = 12'h507;
    localparam logic [11:0] RSC_IDX_PRIO0 = 12'h600;
    localparam logic [11:0] RSC_IDX_PRIO7 = 12'h607;
    localparam logic [11:0] RSC_IDX_LOOP_MODE = 12'ha01;
    localparam logic [11:0] RSC_IDX_STATUS = 12'ha20;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RSC_LM_FORCE_HOLD_BIT = 6;
    localparam int RSC_LM_FORCE_FREE_BIT = 5;
    localparam int RSC_LM_MODE_MSB = 4;
    localparam int RSC_LM_MODE_LSB = 3;
    localparam int RSC_LM_USER_MSB = 2;
    localparam int RSC_TBL_ASSIGNED_BIT = 7;
    localparam int RSC_TBL_PROF_MSB = 6;
    localparam int RSC_TBL_PROF_LSB = 4;
    localparam int RSC_PRIO_SEL_LSB = 0;
    localparam int RSC_PRIO_PROM_LSB = 4;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RSC_RST_LOOP_MODE = 8'h00;
    localparam logic [7:0] RSC_RST_PBO_THRESH = 8'h00;
    localparam logic [7:0] RSC_RST_FTW_BYTE = 8'h00;
    localparam logic [7:0] RSC_RST_PRIO = 8'h00;
    // ----------------------------------------------------------------
    // selection modes and controller states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RSC_MODE_AUTO = 2'b00,
        RSC_MODE_FALLBACK = 2'b01,
        RSC_MODE_HOLDOVER = 2'b10,
        RSC_MODE_MANUAL = 2'b11
    } rsc_mode_e;
    typedef enum logic [1:0] {
        RSC_ST_HOLD = 2'b00,
        RSC_ST_TRACK = 2'b01,
        RSC_ST_FREE = 2'b11
    } rsc_state_e;
endpackage

// ### testbench/rsc_props.sv
// port checker for the reference switchover controller
// assumes it is bound to the controller; one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module rsc_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [2:0] active_ref_o,
    input wire logic ref_active_o,
    input wire logic holdover_o,
    input wire logic free_run_o,
    input wire logic switch_o,
    input wire logic phase_buildout_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // selection outputs
    // ----------------------------------------------------------------
    property p_one_state; $onehot({ref_active_o, holdover_o, free_run_o}); endproperty
    a_one_state: assert property (p_one_state) else $error("state not one-hot");
    property p_rise_sw; $rose(ref_active_o) |-> switch_o; endproperty
    a_rise_sw: assert property (p_rise_sw) else $error("no switch on entry");
    property p_move_sw; ref_active_o && $changed(active_ref_o) |-> switch_o; endproperty
    a_move_sw: assert property (p_move_sw) else $error("no switch on move");
    property p_pb_sw; phase_buildout_o |-> switch_o; endproperty
    a_pb_sw: assert property (p_pb_sw) else $error("build-out without switch");
    // the pulse is launched on the same edge as the state and index change
    property p_sw_cause;
        switch_o |-> ref_active_o && (!$past(ref_active_o) || $changed(active_ref_o));
    endproperty
    a_sw_cause: assert property (p_sw_cause) else $error("switch while idle");
    property p_hold_still; !ref_active_o ##1 !ref_active_o |-> $stable(active_ref_o); endproperty
    a_hold_still: assert property (p_hold_still) else $error("index moved idle");
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
endmodule
bind rsc_reference_switchover_control rsc_props i_props (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .active_ref_o, .ref_active_o,
    .holdover_o, .free_run_o, .switch_o, .phase_buildout_o);
`default_nettype wire

// ### testbench/rsc_ref_src_model.sv
// reference source model: validation monitors and profile table
// assumes the bench sets wanted levels just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module rsc_ref_src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] valid_i,
    input wire logic [7:0] assigned_i,
    input wire logic [23:0] profile_i,
    output logic [7:0] ref_valid_o,
    output logic [63:0] ref_profile_o
);
    // ----------------------------------------------------------------
    // table entries
    // ----------------------------------------------------------------
    // null entries carry inverted profile bits and the spare nibble is
    // junk, so a reader that skips the assigned bit is caught
    always_ff @(posedge clk_i) begin
        for (int r = 0; r < 8; r++) begin
            ref_profile_o[8*r +: 8] <= {assigned_i[r],
                assigned_i[r] ? profile_i[3*r +: 3] : ~profile_i[3*r +: 3], 4'ha};
        end
        ref_valid_o <= rst_i ? 8'h00 : valid_i;
    end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the reference switchover controller
// assumes the reference source model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rsc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [13:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] dat_o, q;
    logic ack, ra, ho, fr, sw, pb;
    logic [7:0] vld = '0;
    logic [7:0] asg = '0;
    logic [23:0] prf = '0;
    logic [7:0] r_vld;
    logic [63:0] r_prf;
    logic [2:0] act;
    logic [47:0] ftw;
    // mode, user code, user valid, expected {track, hold, free, active}
    logic [11:0] rows [8] = '{12'h3e3, 12'h7a3, 12'h7e7, 12'hbe7,
        12'hb97, 12'hfa7, 12'hc20, 12'h023};
    int n_mismatch = 0;
    int cmp_count = 0;
    rsc_reference_switchover_control i_dut (.clk_i, .rst_i,
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ref_valid_i(r_vld), .ref_profile_i(r_prf), .active_ref_o(act),
        .ref_active_o(ra), .holdover_o(ho), .free_run_o(fr), .ftw_o(ftw),
        .switch_o(sw), .phase_buildout_o(pb));
    rsc_ref_src_model i_src (.clk_i, .rst_i, .valid_i(vld), .assigned_i(asg),
        .profile_i(prf), .ref_valid_o(r_vld), .ref_profile_o(r_prf));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk_reg(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_sel(input string nm, input logic [5:0] e);
        chk_reg(nm, {42'h0, e}, {42'h0, ra, ho, fr, act});
    endtask
    // request held until ack is seen, then released for one cycle
    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        q = dat_o;
        cyc <= 1'b0;
        if (n >= 40) chk_reg("bus ack", 48'h1, 48'h0);
        @(posedge clk_i);
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk_reg(nm, {40'h0, e}, {16'h0, q});
    endtask
    task automatic refs(input logic [7:0] v, input logic [7:0] a, input logic [23:0] p);
        vld <= v;
        asg <= a;
        prf <= p;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic see_sw(input logic e);
        int n;
        n = 0;
        while (sw !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk_reg("switch and build-out", {46'h0, 1'b1, e}, {46'h0, sw, pb});
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd_chk("loop mode", RSC_IDX_LOOP_MODE, 8'h00);
        rd_chk("threshold", RSC_IDX_PBO_THRESH, 8'h00);
        rd_chk("status", RSC_IDX_STATUS, 8'h20);
        wb(1'b1, 12'h100, 8'hff);
        rd_chk("unmapped", 12'h100, 8'h00);
        wb(1'b1, RSC_IDX_PBO_THRESH, 8'hff);
        rd_chk("threshold", RSC_IDX_PBO_THRESH, 8'h07);
        wb(1'b1, RSC_IDX_PBO_THRESH, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_auto;
        wb(1'b1, RSC_IDX_PRIO0, 8'h13);
        wb(1'b1, RSC_IDX_PRIO0 + 12'h1, 8'h22);
        refs(8'h4d, 8'h4e, 24'h040209);
        chk_sel("auto pick", 6'h23);
        rd_chk("status", RSC_IDX_STATUS, 8'h93);
        refs(8'h04, 8'h4e, 24'h040209);
        chk_sel("active fails", 6'h22);
        refs(8'h0c, 8'h4e, 24'h040209);
        chk_sel("promoted holds", 6'h22);
        wb(1'b1, RSC_IDX_PRIO0, 8'h33);
        repeat (4) @(posedge clk_i);
        chk_sel("better candidate", 6'h23);
        $display("test auto done");
    endtask
    task automatic t_modes;
        foreach (rows[i]) begin
            refs({rows[i][6], 7'h08}, 8'h89, 24'h000200);
            wb(1'b1, RSC_IDX_LOOP_MODE, {3'b000, rows[i][11:7]});
            repeat (4) @(posedge clk_i);
            chk_sel("mode table", rows[i][5:0]);
        end
        $display("test modes done");
    endtask
    task automatic t_force;
        wb(1'b1, RSC_IDX_LOOP_MODE, 8'h40);
        chk_sel("forced holdover", 6'h13);
        wb(1'b1, RSC_IDX_LOOP_MODE, 8'h20);
        chk_sel("forced free-run", 6'h0b);
        wb(1'b1, RSC_IDX_LOOP_MODE, 8'h60);
        chk_sel("both forced", 6'h0b);
        wb(1'b1, RSC_IDX_LOOP_MODE, 8'h00);
        chk_sel("released", 6'h23);
        for (int g = 0; g < 6; g++) begin
            wb(1'b1, RSC_IDX_FTW0 + 12'(g), 8'(8'h11 * (g + 1)));
        end
        chk_reg("tuning word", 48'h665544332211, ftw);
        rd_chk("tuning top", RSC_IDX_FTW5, 8'h66);
        $display("test force done");
    endtask
    task automatic t_pbo;
        wb(1'b1, RSC_IDX_PBO_THRESH, 8'h03);
        refs(8'h00, 8'h89, 24'h000200);
        vld <= 8'h08;
        see_sw(1'b0);
        wb(1'b1, RSC_IDX_PBO_THRESH, 8'h02);
        refs(8'h00, 8'h89, 24'h000200);
        vld <= 8'h08;
        see_sw(1'b1);
        $display("test build-out done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_auto;
        t_modes;
        t_force;
        t_pbo;
        wrap_up;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        wrap_up;
    end
endmodule
`default_nettype wire
